// ===== logic/tbfrt_timer.sv
// time base counter and 8-bit free-running timer with classic wishbone slave
`timescale 1ns/1ns
`include "tbfrt_regs.svh"
module tbfrt_timer
    import tbfrt_pkg::*;
(
    input wire logic clk_i, // system clock, 10 MHz
    input wire logic rst_i, // synchronous reset, active high
    input wire logic high_osc_clk_i, // high-speed oscillator clock, sampled
    input wire logic low_osc_clock_i, // low-speed oscillator clock, sampled
    input wire logic system_clock_div_i, // divided system clock level, sampled
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write enable
    input wire logic [17:0] wb_adr_i, // wishbone byte address
    input wire logic [7:0] wb_dat_i, // wishbone write data
    input wire logic wb_sel_i, // wishbone byte select
    output logic [7:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o, // wishbone acknowledge
    output logic base_interrupt_request_o, // time base request flag level
    output logic free_run_interrupt_request_o // free-running request flag level
);

    // ==========================================================
    // helpers
    // ==========================================================
    // falling edge of a resynchronised level: older sample high, newer low
    function automatic logic fall_det(input logic newer, input logic older);
        fall_det = older & ~newer;
    endfunction : fall_det

    function automatic logic rise_det(input logic newer, input logic older);
        rise_det = newer & ~older;
    endfunction : rise_det

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    // three stages; only stages 2 and 3 are compared, stage 1 feeds stage 2 alone
    logic [2:0] hi_sync_ff, lo_sync_ff, sd_sync_ff;
    logic [2:0] nxt_hi_sync, nxt_lo_sync, nxt_sd_sync;

    always_comb
    begin
        nxt_hi_sync = {hi_sync_ff[1:0], high_osc_clk_i};
        nxt_lo_sync = {lo_sync_ff[1:0], low_osc_clock_i};
        nxt_sd_sync = {sd_sync_ff[1:0], system_clock_div_i};
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hi_sync_ff <= 3'h0;
            lo_sync_ff <= 3'h0;
            sd_sync_ff <= 3'h0;
        end
        else
        begin
            hi_sync_ff <= nxt_hi_sync;
            lo_sync_ff <= nxt_lo_sync;
            sd_sync_ff <= nxt_sd_sync;
        end
    end

    // ==========================================================
    // registers and bus slave
    // ==========================================================
    logic [7:0] mode_ff, cmp_ff, nxt_mode, nxt_cmp, nxt_rdata;
    logic [1:0] run_ff, nxt_run;
    logic fic_ff, bic_ff, nxt_fic, nxt_bic;
    logic ack_ff, nxt_ack;
    logic [7:0] rdata_ff;
    logic req, wr, cmp_wr, bclr_wr, fic_wr, bic_wr;
    logic [14:0] base_ff, nxt_base;
    logic [7:0] frc_ff, nxt_frc;
    logic frq_ff, nxt_frq, brq_ff, nxt_brq;

    // one wait state: ack comes the edge after the request is seen, then drops
    assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr = req & wb_we_i & wb_sel_i;
    assign cmp_wr = wr & (wb_adr_i == `TBFRT_ADR_CMP);
    assign bclr_wr = wr & (wb_adr_i == `TBFRT_ADR_BCLR);
    assign fic_wr = wr & (wb_adr_i == `TBFRT_ADR_FICR);
    assign bic_wr = wr & (wb_adr_i == `TBFRT_ADR_BICR);

    // register writes and read mux; unmapped addresses read zero and still ack
    always_comb
    begin
        nxt_ack = req;
        nxt_mode = mode_ff;
        nxt_run = run_ff;
        nxt_cmp = cmp_ff;
        nxt_rdata = `TBFRT_ZERO8;
        if (wr & (wb_adr_i == `TBFRT_ADR_MODE))
        begin
            nxt_mode = wb_dat_i;
        end
        if (wr & (wb_adr_i == `TBFRT_ADR_RUN))
        begin
            nxt_run = wb_dat_i[1:0];
        end
        if (cmp_wr)
        begin
            nxt_cmp = wb_dat_i;
        end
        if (wb_adr_i == `TBFRT_ADR_COUNT)
        begin
            nxt_rdata = frc_ff;
        end
        else if (wb_adr_i == `TBFRT_ADR_CMP)
        begin
            nxt_rdata = cmp_ff;
        end
        else if (wb_adr_i == `TBFRT_ADR_MODE)
        begin
            nxt_rdata = mode_ff;
        end
        else if (wb_adr_i == `TBFRT_ADR_RUN)
        begin
            nxt_rdata = {6'h00, run_ff};
        end
        else if (wb_adr_i == `TBFRT_ADR_FICR)
        begin
            nxt_rdata = {7'h00, frq_ff};
        end
        else if (wb_adr_i == `TBFRT_ADR_BICR)
        begin
            nxt_rdata = {7'h00, brq_ff};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
            mode_ff <= `TBFRT_MODE_RST;
            run_ff <= 2'h0;
            cmp_ff <= `TBFRT_CMP_RST;
            rdata_ff <= `TBFRT_ZERO8;
        end
        else
        begin
            ack_ff <= nxt_ack;
            mode_ff <= nxt_mode;
            run_ff <= nxt_run;
            cmp_ff <= nxt_cmp;
            rdata_ff <= nxt_rdata;
        end
    end

    // ==========================================================
    // time base counter
    // ==========================================================
    logic b_src_new, b_src_old, b_tick, b_tap, b_tap_d_ff, b_period;
    logic t7_new, t7_old, t13_new, t13_old;
    logic [14:0] base_prev_ff;

    // low-speed source when mode bit 0 set, high-speed otherwise
    assign b_src_new = mode_ff[0] ? lo_sync_ff[1] : hi_sync_ff[1];
    assign b_src_old = mode_ff[0] ? lo_sync_ff[2] : hi_sync_ff[2];
    assign b_tick = fall_det(b_src_new, b_src_old) & run_ff[`TBFRT_BIT_BRUN];

    // period tap; a falling edge of tap bit k marks 2^(k+1) source clocks
    always_comb
    begin
        case (mode_ff[6:4])
            3'h0: b_tap = base_ff[`TBFRT_TAP7];
            3'h1: b_tap = base_ff[`TBFRT_TAP8];
            3'h2: b_tap = base_ff[`TBFRT_TAP9];
            3'h3: b_tap = base_ff[`TBFRT_TAP10];
            3'h4, 3'h5: b_tap = base_ff[`TBFRT_TAP13];
            default: b_tap = base_ff[`TBFRT_TAP15];
        endcase
    end
    assign b_period = fall_det(b_tap, b_tap_d_ff);

    // clear wins over a count tick: software reset must never be lost
    always_comb
    begin
        nxt_base = base_ff;
        if (bclr_wr)
        begin
            nxt_base = `TBFRT_ZERO15;
        end
        else if (b_tick)
        begin
            nxt_base = base_ff + `TBFRT_ONE15;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            base_ff <= `TBFRT_ZERO15;
            base_prev_ff <= `TBFRT_ZERO15;
            b_tap_d_ff <= 1'b0;
        end
        else
        begin
            base_ff <= nxt_base;
            base_prev_ff <= base_ff;
            b_tap_d_ff <= b_tap;
        end
    end

    // base taps as raw timer clocks; edges come from consecutive counter states
    assign t7_new = base_ff[`TBFRT_TAP7];
    assign t7_old = base_prev_ff[`TBFRT_TAP7];
    assign t13_new = base_ff[`TBFRT_TAP13];
    assign t13_old = base_prev_ff[`TBFRT_TAP13];

    // ==========================================================
    // free-running counter
    // ==========================================================
    logic f_tick, f_match, f_set;
    logic [1:0] blk_ff, nxt_blk;
    logic match_pend_ff, nxt_match_pend;
    logic t7s_ff, t13s_ff;
    tbfrt_clk_sel_t fsel;

    assign fsel = tbfrt_clk_sel_t'(mode_ff[3:1]);

    // synchronized tap options go through an extra system-clock stage
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            t7s_ff <= 1'b0;
            t13s_ff <= 1'b0;
        end
        else
        begin
            t7s_ff <= t7_old;
            t13s_ff <= t13_old;
        end
    end

    // count enable per source; falling edges except for the system clock
    always_comb
    begin
        case (fsel)
            TBFRT_CK_HIGH: f_tick = fall_det(hi_sync_ff[1], hi_sync_ff[2]);
            TBFRT_CK_SYS: f_tick = rise_det(sd_sync_ff[1], sd_sync_ff[2]);
            TBFRT_CK_LOW: f_tick = fall_det(lo_sync_ff[1], lo_sync_ff[2]);
            // the pin synchroniser already resamples the low clock, so raw and synchronized agree
            TBFRT_CK_LOW_SYNC: f_tick = fall_det(lo_sync_ff[1], lo_sync_ff[2]);
            TBFRT_CK_T13: f_tick = fall_det(t13_new, t13_old);
            TBFRT_CK_T13_SYNC: f_tick = fall_det(t13_old, t13s_ff);
            TBFRT_CK_T7: f_tick = fall_det(t7_new, t7_old);
            default: f_tick = fall_det(t7_old, t7s_ff);
        endcase
    end

    // equality only, so a compare below the count waits for the wrap
    assign f_match = (frc_ff == cmp_ff);
    // flag only with clear-select 1 and outside the blocking window
    assign f_set = f_tick & run_ff[`TBFRT_BIT_FRUN] & match_pend_ff
        & mode_ff[`TBFRT_BIT_CLRSEL] & (blk_ff == 2'h0);

    always_comb
    begin
        nxt_frc = frc_ff;
        nxt_match_pend = match_pend_ff;
        nxt_blk = (blk_ff != 2'h0) ? blk_ff - 2'h1 : 2'h0;
        if (cmp_wr & ~mode_ff[`TBFRT_BIT_CLRSEL])
        begin
            nxt_frc = `TBFRT_ZERO8;
            nxt_match_pend = 1'b0;
        end
        else if (f_tick & run_ff[`TBFRT_BIT_FRUN])
        begin
            if (match_pend_ff)
            begin
                nxt_frc = `TBFRT_ZERO8;
                nxt_match_pend = 1'b0;
            end
            else
            begin
                nxt_frc = frc_ff + 8'h01;
                nxt_match_pend = (nxt_frc == cmp_ff);
            end
        end
        else if (~match_pend_ff)
        begin
            nxt_match_pend = f_match & run_ff[`TBFRT_BIT_FRUN];
        end
        if (f_set)
        begin
            nxt_blk = `TBFRT_BLOCK_CYC;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            frc_ff <= `TBFRT_ZERO8;
            match_pend_ff <= 1'b0;
            blk_ff <= 2'h0;
        end
        else
        begin
            frc_ff <= nxt_frc;
            match_pend_ff <= nxt_match_pend;
            blk_ff <= nxt_blk;
        end
    end

    // ==========================================================
    // request flags
    // ==========================================================
    // set beats a software clear in the same cycle
    always_comb
    begin
        nxt_frq = frq_ff;
        nxt_brq = brq_ff;
        if (fic_wr)
        begin
            nxt_frq = wb_dat_i[`TBFRT_BIT_IRQ];
        end
        if (bic_wr)
        begin
            nxt_brq = wb_dat_i[`TBFRT_BIT_IRQ];
        end
        if (f_set)
        begin
            nxt_frq = 1'b1;
        end
        if (b_period)
        begin
            nxt_brq = 1'b1;
        end
        nxt_fic = nxt_frq;
        nxt_bic = nxt_brq;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            frq_ff <= 1'b0;
            brq_ff <= 1'b0;
            fic_ff <= 1'b0;
            bic_ff <= 1'b0;
        end
        else
        begin
            frq_ff <= nxt_frq;
            brq_ff <= nxt_brq;
            fic_ff <= nxt_fic;
            bic_ff <= nxt_bic;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdata_ff;
    assign free_run_interrupt_request_o = fic_ff;
    assign base_interrupt_request_o = bic_ff;

endmodule : tbfrt_timer

// ===== logic/tbfrt_regs.svh
// register offsets, field positions and reset values of the time base and free-running timer
`ifndef TBFRT_REGS_SVH
`define TBFRT_REGS_SVH
`define TBFRT_ADR_COUNT 18'h03F60
`define TBFRT_ADR_CMP 18'h03F61
`define TBFRT_ADR_MODE 18'h03F62
`define TBFRT_ADR_BCLR 18'h03F63
`define TBFRT_ADR_RUN 18'h03F64
`define TBFRT_ADR_FICR 18'h03FEB
`define TBFRT_ADR_BICR 18'h03FEC
`define TBFRT_MODE_RST 8'h00
`define TBFRT_CMP_RST 8'hFF
`define TBFRT_ZERO8 8'h00
`define TBFRT_ZERO15 15'h0000
`define TBFRT_ONE15 15'h0001
`define TBFRT_BIT_CLRSEL 7
`define TBFRT_BIT_FRUN 0
`define TBFRT_BIT_BRUN 1
`define TBFRT_BIT_IRQ 0
`define TBFRT_BLOCK_CYC 2'h3
`define TBFRT_TAP7 6
`define TBFRT_TAP8 7
`define TBFRT_TAP9 8
`define TBFRT_TAP10 9
`define TBFRT_TAP13 12
`define TBFRT_TAP15 14
`endif

// ===== logic/tbfrt_pkg.sv
// types shared by the time base and free-running timer
package tbfrt_pkg;
    typedef enum logic [2:0]
    {
        TBFRT_CK_HIGH = 3'h0,
        TBFRT_CK_SYS = 3'h1,
        TBFRT_CK_LOW = 3'h2,
        TBFRT_CK_LOW_SYNC = 3'h3,
        TBFRT_CK_T13 = 3'h4,
        TBFRT_CK_T13_SYNC = 3'h5,
        TBFRT_CK_T7 = 3'h6,
        TBFRT_CK_T7_SYNC = 3'h7
    } tbfrt_clk_sel_t;
endpackage : tbfrt_pkg

// ===== testbench/tbfrt_timer_chk.sv
// bus and request-port checker for the timer block
`timescale 1ns/1ns
`include "tbfrt_regs.svh"
module tbfrt_timer_chk
(
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write
    input wire logic [17:0] wb_adr_i, // address
    input wire logic [7:0] wb_dat_i, // write data
    input wire logic wb_sel_i, // select
    input wire logic [7:0] wb_dat_o, // read data
    input wire logic wb_ack_o, // ack
    input wire logic base_interrupt_request_o, // base request
    input wire logic free_run_interrupt_request_o // free-run request
);
    // ==========================================================
    // shadow of mode and run bits, quiet-time counters
    logic tk;
    logic [7:0] md_ff;
    logic [1:0] rn_ff;
    logic [2:0] fq_ff;
    logic [2:0] bq_ff;
    assign tk = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i && !wb_ack_o;
    // flag, clear and mode writes restart a count: software or a tap switch may set a flag
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            md_ff <= 8'h00;
            rn_ff <= 2'h0;
            fq_ff <= 3'h0;
            bq_ff <= 3'h0;
        end
        else
        begin
            if (tk && wb_adr_i == `TBFRT_ADR_MODE)
                md_ff <= wb_dat_i;
            if (tk && wb_adr_i == `TBFRT_ADR_RUN)
                rn_ff <= wb_dat_i[1:0];
            fq_ff <= (rn_ff[0] && md_ff[7]) || (tk && wb_adr_i == `TBFRT_ADR_FICR) ? 3'h0
                : fq_ff + {2'h0, fq_ff != 3'h7};
            bq_ff <= rn_ff[1] || (tk && wb_adr_i inside {`TBFRT_ADR_BICR, `TBFRT_ADR_BCLR, `TBFRT_ADR_MODE})
                ? 3'h0 : bq_ff + {2'h0, bq_ff != 3'h7};
        end
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_once;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack missing after request");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    property p_ack_cause;
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_read_zero;
        wb_ack_o && !wb_we_i && !(wb_adr_i inside {`TBFRT_ADR_COUNT, `TBFRT_ADR_CMP, `TBFRT_ADR_MODE,
            `TBFRT_ADR_RUN, `TBFRT_ADR_FICR, `TBFRT_ADR_BICR}) |-> wb_dat_o == 8'h00;
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("nonzero read of empty place");
    property p_rst_quiet;
        $fell(rst_i) |-> !wb_ack_o && !base_interrupt_request_o && !free_run_interrupt_request_o;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
    property p_fr_quiet;
        fq_ff == 3'h7 |-> !$rose(free_run_interrupt_request_o);
    endproperty
    a_fr_quiet: assert property (p_fr_quiet) else $error("free-run request while barred");
    property p_base_quiet;
        bq_ff == 3'h7 |-> !$rose(base_interrupt_request_o);
    endproperty
    a_base_quiet: assert property (p_base_quiet) else $error("base request while stopped");
    property p_fr_gap;
        $rose(free_run_interrupt_request_o) |=> !$rose(free_run_interrupt_request_o) [*3];
    endproperty
    a_fr_gap: assert property (p_fr_gap) else $error("free-run requests too close");
endmodule : tbfrt_timer_chk

bind tbfrt_timer tbfrt_timer_chk u_chk
(
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .base_interrupt_request_o(base_interrupt_request_o),
    .free_run_interrupt_request_o(free_run_interrupt_request_o)
);

// ===== testbench/tbfrt_timer_tb.sv
// self-checking bench for the time base and free-running timer
`timescale 1ns/1ns
`include "tbfrt_regs.svh"
module tbfrt_timer_tb
    import tbfrt_pkg::*;
;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic high_osc_clk_i = 1'h0, low_osc_clock_i = 1'h0, system_clock_div_i = 1'h0;
    logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_sel_i = 1'h0;
    logic [17:0] wb_adr_i = 18'h00000;
    logic [7:0] wb_dat_i = 8'h00;
    logic [7:0] wb_dat_o;
    logic wb_ack_o, base_interrupt_request_o, free_run_interrupt_request_o;
    logic [3:0] ph = 4'h0;
    int errors = 0;
    int check_count = 0;
    localparam logic [17:0] ad_cnt = `TBFRT_ADR_COUNT, ad_cmp = `TBFRT_ADR_CMP, ad_md = `TBFRT_ADR_MODE;
    localparam logic [17:0] ad_clr = `TBFRT_ADR_BCLR, ad_run = `TBFRT_ADR_RUN;
    localparam logic [17:0] ad_fi = `TBFRT_ADR_FICR, ad_bi = `TBFRT_ADR_BICR;
    int lo [8] = '{136, 21, 31, 31, 0, 0, 1, 1};
    int hi [8] = '{144, 29, 39, 39, 0, 0, 1, 1};
    logic [7:0] md [6] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h50, 8'h01};
    int ex [6] = '{512, 1024, 2048, 4096, 32768, 2048};

    tbfrt_timer dut
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .high_osc_clk_i(high_osc_clk_i),
        .low_osc_clock_i(low_osc_clock_i),
        .system_clock_div_i(system_clock_div_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .base_interrupt_request_o(base_interrupt_request_o),
        .free_run_interrupt_request_o(free_run_interrupt_request_o)
    );
    // ==========================================================
    // clocks: 100 ns system, oscillators stepped off it (4 and 16 cycles)
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        ph <= ph + 4'h1;
        high_osc_clk_i <= ph[1];
        low_osc_clock_i <= ph[3];
        system_clock_div_i <= ph[0];
    end
    // ==========================================================
    // helpers
    task end_of_test;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task hang;
        errors++;
        end_of_test;
    endtask : hang
    task chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task rng(input logic [7:0] c, input int l, input int h);
        chk({7'h00, c >= l && c <= h}, 8'h01);
    endtask : rng
    task wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wt
    // one classic cycle; the request stands until ack is sampled, then drops for a cycle
    task bus(input logic we, input logic [17:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 1'h1;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'h1 && n < 16);
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        if (n == 16)
            hang();
        @(posedge clk_i);
    endtask : bus
    task wr(input logic [17:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'h1, a, d, q);
    endtask : wr
    task rd(input logic [17:0] a, output logic [7:0] q);
        bus(1'h0, a, 8'h00, q);
    endtask : rd
    task rdc(input logic [17:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'h0, a, 8'h00, q);
        chk(q, e);
    endtask : rdc
    // cycles until the chosen request is high, bounded
    task rise(input logic f, input int lim, output int n);
        n = 0;
        while ((f ? free_run_interrupt_request_o : base_interrupt_request_o) !== 1'h1 && n < lim)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n == lim)
            hang();
    endtask : rise
    // ==========================================================
    // scenarios
    task t_reset;
        rdc(ad_cnt, 8'h00);
        rdc(ad_cmp, `TBFRT_CMP_RST);
        rdc(ad_md, `TBFRT_MODE_RST);
        rdc(ad_fi, 8'h00);
        rdc(ad_clr, 8'h00);
        wr(18'h03F65, 8'hFF);
        rdc(18'h03F65, 8'h00);
    endtask : t_reset
    // rising-edge system source: rate, stop, clear on compare write, hold with clear-select set
    task t_count;
        logic [7:0] c;
        wr(ad_md, 8'h02);
        wr(ad_run, 8'h01);
        wt(40);
        wr(ad_run, 8'h00);
        rd(ad_cnt, c);
        rng(c, 17, 25);
        wt(10);
        rdc(ad_cnt, c);
        wr(ad_cmp, 8'h80);
        rdc(ad_cnt, 8'h00);
        wr(ad_md, 8'h82);
        wr(ad_run, 8'h01);
        wt(20);
        wr(ad_run, 8'h00);
        rd(ad_cnt, c);
        rng(c, 8, 14);
        wr(ad_cmp, 8'hFF);
        rdc(ad_cnt, c);
    endtask : t_count
    // match with clear-select 0 then 1; compare 3 gives four counts, eight cycles
    task t_match;
        logic [7:0] c;
        int n;
        wr(ad_md, 8'h02);
        wr(ad_cmp, 8'h03);
        wr(ad_run, 8'h01);
        wt(40);
        rdc(ad_fi, 8'h00);
        rd(ad_cnt, c);
        rng(c, 0, 3);
        wr(ad_md, 8'h82);
        rise(1'h1, 40, n);
        wr(ad_fi, 8'h00);
        wt(1);
        rise(1'h1, 40, n);
        chk(8'(n + 4), 8'h08);
        wr(ad_run, 8'h00);
        wr(ad_fi, 8'h00);
    endtask : t_match
    // compare moved below the running count: no match until after overflow
    task t_wrap;
        logic [7:0] c;
        wr(ad_md, 8'h02);
        wr(ad_cmp, 8'hFF);
        wr(ad_md, 8'h82);
        wr(ad_run, 8'h01);
        wt(40);
        wr(ad_cmp, 8'h05);
        wt(30);
        wr(ad_run, 8'h00);
        rd(ad_cnt, c);
        rng(c, 33, 43);
        rdc(ad_fi, 8'h00);
    endtask : t_wrap
    // each free-running source over about 563 cycles, time base from the high oscillator
    task t_src;
        logic [7:0] c;
        tbfrt_clk_sel_t s;
        for (int i = 0; i < 8; i++)
        begin
            s = tbfrt_clk_sel_t'(i);
            wr(ad_md, {4'h0, s, 1'h0});
            wr(ad_cmp, 8'hFF);
            wr(ad_clr, 8'h00);
            wr(ad_run, 8'h03);
            wt(560);
            wr(ad_run, 8'h00);
            rd(ad_cnt, c);
            rng(c, lo[i], hi[i]);
        end
    endtask : t_src
    // time base period per cycle field and source, timed from start after a clear
    task t_base;
        int n;
        for (int i = 0; i < 6; i++)
        begin
            wr(ad_run, 8'h00);
            wr(ad_md, md[i]);
            wr(ad_clr, 8'h00);
            wr(ad_clr, 8'h00);
            wt(4);
            wr(ad_bi, 8'h00);
            wt(8);
            chk({7'h00, base_interrupt_request_o}, 8'h00);
            wr(ad_run, 8'h02);
            rise(1'h0, 40000, n);
            chk({7'h00, n >= ex[i] - 8 && n <= ex[i] + 20}, 8'h01);
        end
    endtask : t_base
    // cycle field 11x: still quiet past the point where 10x would have raised a request
    task t_long;
        wr(ad_run, 8'h00);
        wr(ad_md, 8'h60);
        wr(ad_clr, 8'h00);
        wr(ad_bi, 8'h00);
        wr(ad_run, 8'h02);
        wt(33000);
        chk({7'h00, base_interrupt_request_o}, 8'h00);
        wr(ad_run, 8'h00);
    endtask : t_long
    // ==========================================================
    // main sequence: reset held 4 cycles
    initial
    begin
        wt(4);
        rst_i <= 1'h0;
        @(posedge clk_i);
        t_reset;
        t_count;
        t_match;
        t_wrap;
        t_src;
        t_base;
        t_long;
        end_of_test;
    end
endmodule : tbfrt_timer_tb
